/* File: common/cscr_regs.svh */
`ifndef CSCR_REGS_SVH
`define CSCR_REGS_SVH
// Register selects on the core data port
`define CSCR_SEL_STATUS   2'h0
`define CSCR_SEL_CONTROL  2'h1
`define CSCR_SEL_WSET     2'h2
// Status field positions
`define CSCR_ST_AOVF      15
`define CSCR_ST_BOVF      14
`define CSCR_ST_ACLIP     13
`define CSCR_ST_BCLIP     12
`define CSCR_ST_ANY_OVF   11
`define CSCR_ST_ANY_CLIP  10
`define CSCR_ST_DO_BUSY   9
`define CSCR_ST_HALF      8
`define CSCR_ST_LVL_HI    7
`define CSCR_ST_LVL_LO    5
`define CSCR_ST_REP_BUSY  4
`define CSCR_ST_NEG       3
`define CSCR_ST_SOVF      2
`define CSCR_ST_ZERO      1
`define CSCR_ST_CARRY     0
// Control field positions
`define CSCR_CC_VAR       15
`define CSCR_CC_MUL_HI    13
`define CSCR_CC_MUL_LO    12
`define CSCR_CC_EXIT      11
`define CSCR_CC_NEST_HI   10
`define CSCR_CC_NEST_LO   8
`define CSCR_CC_ACLIP_EN  7
`define CSCR_CC_BCLIP_EN  6
`define CSCR_CC_SCLIP_EN  5
`define CSCR_CC_CLIP_W    4
`define CSCR_CC_LVL_TOP   3
`define CSCR_CC_FRAME     2
`define CSCR_CC_ROUND     1
`define CSCR_CC_INT_MUL   0
// Reset values
`define CSCR_STATUS_RST   16'h0000
`define CSCR_CONTROL_RST  16'h0020
// Reserved multiply signedness code
`define CSCR_MUL_RSVD     2'h3
// Priority level that blocks user interrupts
`define CSCR_LVL_BLOCK    3'h7
`endif

/* File: common/cscr_pkg.sv */
package cscr_pkg;
	typedef enum logic [1:0] {
		CSCR_MUL_SIGNED = 2'h0,
		CSCR_MUL_UNSIGNED = 2'h1,
		CSCR_MUL_MIXED = 2'h2
	} cscr_mul_t;

	// ALU flag update from the datapath
	typedef struct packed {
		logic n;
		logic ov;
		logic z;
		logic c;
		logic dc;
	} cscr_alu_t;
endpackage

/* File: common/cscr_flag_if.sv */
`timescale 1ns/10ps
// Carries one ALU flag update between the top and the flag unit
interface cscr_flag_if;
	logic                    upd;
	logic [15:0]             result;
	logic                    carry_out;
	logic                    half_out_b;
	logic                    half_out_w;
	logic                    is_byte;
	logic                    ovf;
	cscr_pkg::cscr_alu_t     flags;
	modport src (output upd, output result, output carry_out,
		output half_out_b, output half_out_w, output is_byte,
		output ovf, input flags);
	modport dst (input upd, input result, input carry_out,
		input half_out_b, input half_out_w, input is_byte,
		input ovf, output flags);
endinterface // cscr_flag_if

/* File: rtl/cscr_flag_eval.sv */
`timescale 1ns/10ps
// Derives the next ALU condition flags from one result
module cscr_flag_eval (
	cscr_flag_if.dst fl
);
	// Byte results take sign from bit 7, words from bit 15
	always_comb begin
		fl.flags.n  = fl.is_byte ? fl.result[7] : fl.result[15];
		fl.flags.ov = fl.ovf;
		fl.flags.z  = fl.is_byte ? (fl.result[7:0] == 8'h00)
			: (fl.result == 16'h0000);
		fl.flags.c  = fl.carry_out;
		fl.flags.dc = fl.is_byte ? fl.half_out_b : fl.half_out_w;
	end
endmodule // cscr_flag_eval

/* File: rtl/cscr_regs.sv */
`timescale 1ns/10ps
`include "cscr_regs.svh"
// Summary of operation
// - Status bits 15/14 show accumulator overflow
// - Saturation flags stick until software clears
// - Bits 11/10 read OR of pairs
// - Sticky flags written directly or via bit 10
// - Bits 9 and 4 show loop activity
// - Half carry from bit 4 or 8
// - Priority low three plus control bit 3
// - Level 7 or top bit blocks interrupts
// - Priority field locked against register writes when nesting disabled
// - Negative flag follows result sign
// - Signed overflow flag from two's complement
// - Zero flag set by zero result, cleared by non-zero
// - Carry flag is carry or borrow
// - Control 15 latency select, 14 reads zero
// - Multiply signedness field, code 11 reserved
// - Writing early exit ends DO loop
// - Nesting depth read-only, zero to seven
// - Saturation enables, store enable resets one
// - Control 4 selects saturation width
// - Stack frame bit widens pointer addressing
// - Rounding style and integer multiply select
// - Context status reports active, manual set
module cscr_regs (
	input  wire logic        clk,
	input  wire logic        rst_n,
	// Software data port
	input  wire logic [1:0]  reg_sel,
	input  wire logic        reg_wr,
	input  wire logic [15:0] reg_wdata,
	output logic      [15:0] reg_rdata,
	// Accumulator events
	input  wire logic        acc_a_overflow_in,
	input  wire logic        acc_b_overflow_in,
	input  wire logic        acc_a_sat_evt,
	input  wire logic        acc_b_sat_evt,
	// ALU flag update
	input  wire logic        alu_upd,
	input  wire logic [15:0] alu_result,
	input  wire logic        alu_carry,
	input  wire logic        alu_half_b,
	input  wire logic        alu_half_w,
	input  wire logic        alu_is_byte,
	input  wire logic        alu_ovf,
	// Loop hardware and context
	input  wire logic        do_loop_busy,
	input  wire logic        repeat_loop_busy,
	input  wire logic [2:0]  do_nesting_depth,
	input  wire logic        stack_frame_live,
	input  wire logic [2:0]  active_wset_id,
	input  wire logic [2:0]  manual_wset_id,
	input  wire logic        nesting_disable,
	// Hardware priority load from interrupt controller
	input  wire logic        prio_load,
	input  wire logic [3:0]  prio_value,
	// Outputs to the core
	output logic      [3:0]  cpu_priority,
	output logic             user_irq_block,
	output logic             var_latency_en,
	output cscr_pkg::cscr_mul_t dsp_mul_signedness,
	output logic             do_loop_early_exit,
	output logic             acc_a_clip_en,
	output logic             acc_b_clip_en,
	output logic             store_clip_en,
	output logic             clip_width_sel,
	output logic             round_style,
	output logic             int_mul_sel,
	output logic             ptr_full_range
);
	typedef struct packed {
		logic [15:0] st;
		logic [15:0] cc;
		logic [15:0] rd;
		logic        exit_pulse;
	} cscr_state_t;

	cscr_state_t q;
	cscr_state_t next_q;
	cscr_flag_if fl ();

	////////////////////////////////////////////////////////////////////////
	// Flag evaluation
	assign fl.upd        = alu_upd;
	assign fl.result     = alu_result;
	assign fl.carry_out  = alu_carry;
	assign fl.half_out_b = alu_half_b;
	assign fl.half_out_w = alu_half_w;
	assign fl.is_byte    = alu_is_byte;
	assign fl.ovf        = alu_ovf;

	cscr_flag_eval u_flag (
		.fl (fl)
	);

	// Read assembly, shared by the read register
	function automatic logic [15:0] status_view(input logic [15:0] s,
		input logic da, input logic ra);
		logic [15:0] v;
		v = s;
		v[`CSCR_ST_ANY_OVF]  = s[`CSCR_ST_AOVF] | s[`CSCR_ST_BOVF];
		v[`CSCR_ST_ANY_CLIP] = s[`CSCR_ST_ACLIP] | s[`CSCR_ST_BCLIP];
		v[`CSCR_ST_DO_BUSY]  = da;
		v[`CSCR_ST_REP_BUSY] = ra;
		return v;
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Next state
	always_comb begin
		logic wst;
		logic wcc;
		wst = reg_wr && (reg_sel == `CSCR_SEL_STATUS);
		wcc = reg_wr && (reg_sel == `CSCR_SEL_CONTROL);
		next_q = q;
		next_q.exit_pulse = 1'b0;
		if (wst) begin
			next_q.st[`CSCR_ST_AOVF] = reg_wdata[`CSCR_ST_AOVF];
			next_q.st[`CSCR_ST_BOVF] = reg_wdata[`CSCR_ST_BOVF];
			next_q.st[`CSCR_ST_ACLIP] = reg_wdata[`CSCR_ST_ACLIP];
			next_q.st[`CSCR_ST_BCLIP] = reg_wdata[`CSCR_ST_BCLIP];
			// clearing bit 10 clears both sticky flags
			if (!reg_wdata[`CSCR_ST_ANY_CLIP]) begin
				next_q.st[`CSCR_ST_ACLIP] = 1'b0;
				next_q.st[`CSCR_ST_BCLIP] = 1'b0;
			end
			// clearing bit 11 clears both overflow flags
			if (!reg_wdata[`CSCR_ST_ANY_OVF]) begin
				next_q.st[`CSCR_ST_AOVF] = 1'b0;
				next_q.st[`CSCR_ST_BOVF] = 1'b0;
			end
			if (!nesting_disable)
				next_q.st[`CSCR_ST_LVL_HI:`CSCR_ST_LVL_LO] =
					reg_wdata[`CSCR_ST_LVL_HI:`CSCR_ST_LVL_LO];
			next_q.st[3:0] = reg_wdata[3:0];
			next_q.st[`CSCR_ST_HALF] = reg_wdata[`CSCR_ST_HALF];
		end
		// live overflow status from accumulators wins
		if (acc_a_overflow_in)
			next_q.st[`CSCR_ST_AOVF] = 1'b1;
		if (acc_b_overflow_in)
			next_q.st[`CSCR_ST_BOVF] = 1'b1;
		// saturation sets win over a clear
		if (acc_a_sat_evt)
			next_q.st[`CSCR_ST_ACLIP] = 1'b1;
		if (acc_b_sat_evt)
			next_q.st[`CSCR_ST_BCLIP] = 1'b1;
		if (fl.upd) begin
			next_q.st[`CSCR_ST_NEG]  = fl.flags.n;
			next_q.st[`CSCR_ST_SOVF] = fl.flags.ov;
			if (!fl.flags.z)
				next_q.st[`CSCR_ST_ZERO] = 1'b0;
			else
				next_q.st[`CSCR_ST_ZERO] = 1'b1;
			next_q.st[`CSCR_ST_CARRY] = fl.flags.c;
			next_q.st[`CSCR_ST_HALF]  = fl.flags.dc;
		end
		// Derived and loop bits live outside the stored word
		next_q.st[`CSCR_ST_ANY_OVF]  = 1'b0;
		next_q.st[`CSCR_ST_ANY_CLIP] = 1'b0;
		next_q.st[`CSCR_ST_DO_BUSY]  = 1'b0;
		next_q.st[`CSCR_ST_REP_BUSY] = 1'b0;
		if (wcc) begin
			next_q.cc[`CSCR_CC_VAR] = reg_wdata[`CSCR_CC_VAR];
			if (reg_wdata[`CSCR_CC_MUL_HI:`CSCR_CC_MUL_LO] != `CSCR_MUL_RSVD)
				next_q.cc[`CSCR_CC_MUL_HI:`CSCR_CC_MUL_LO] =
					reg_wdata[`CSCR_CC_MUL_HI:`CSCR_CC_MUL_LO];
			// early exit is a write pulse
			next_q.exit_pulse = reg_wdata[`CSCR_CC_EXIT];
			next_q.cc[7:5] = reg_wdata[7:5];
			next_q.cc[`CSCR_CC_CLIP_W] = reg_wdata[`CSCR_CC_CLIP_W];
			// top bit may only be cleared
			if (!reg_wdata[`CSCR_CC_LVL_TOP])
				next_q.cc[`CSCR_CC_LVL_TOP] = 1'b0;
			next_q.cc[`CSCR_CC_ROUND]   = reg_wdata[`CSCR_CC_ROUND];
			next_q.cc[`CSCR_CC_INT_MUL] = reg_wdata[`CSCR_CC_INT_MUL];
		end
		if (prio_load) begin
			next_q.st[`CSCR_ST_LVL_HI:`CSCR_ST_LVL_LO] = prio_value[2:0];
			next_q.cc[`CSCR_CC_LVL_TOP] = prio_value[3];
		end
		// unimplemented and status-only bits stay zero
		next_q.cc[14] = 1'b0;
		next_q.cc[`CSCR_CC_EXIT] = 1'b0;
		next_q.cc[`CSCR_CC_NEST_HI:`CSCR_CC_NEST_LO] = 3'h0;
		next_q.cc[`CSCR_CC_FRAME] = 1'b0;
		// Registered read data
		case (reg_sel)
			`CSCR_SEL_STATUS:
				next_q.rd = status_view(q.st, do_loop_busy,
					repeat_loop_busy);
			`CSCR_SEL_CONTROL: begin
				next_q.rd = q.cc;
				next_q.rd[`CSCR_CC_NEST_HI:`CSCR_CC_NEST_LO] =
					do_nesting_depth;
				next_q.rd[`CSCR_CC_FRAME] = stack_frame_live;
			end
			`CSCR_SEL_WSET:
				next_q.rd = {5'h00, active_wset_id, 5'h00, manual_wset_id};
			default:
				next_q.rd = 16'h0000;
		endcase
	end

	// Single state register; reset leaves store saturation on
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			q.st  <= `CSCR_STATUS_RST;
			q.cc  <= `CSCR_CONTROL_RST;
			q.rd  <= 16'h0000;
			q.exit_pulse <= 1'b0;
		end else begin
			q <= next_q;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Outputs
	assign reg_rdata = q.rd;
	assign cpu_priority = {q.cc[`CSCR_CC_LVL_TOP],
		q.st[`CSCR_ST_LVL_HI:`CSCR_ST_LVL_LO]};
	// block level 7 or any upper level
	assign user_irq_block = q.cc[`CSCR_CC_LVL_TOP] ||
		(q.st[`CSCR_ST_LVL_HI:`CSCR_ST_LVL_LO] == `CSCR_LVL_BLOCK);
	assign var_latency_en = q.cc[`CSCR_CC_VAR];
	assign dsp_mul_signedness =
		cscr_pkg::cscr_mul_t'(q.cc[`CSCR_CC_MUL_HI:`CSCR_CC_MUL_LO]);
	assign do_loop_early_exit = q.exit_pulse;
	assign acc_a_clip_en  = q.cc[`CSCR_CC_ACLIP_EN];
	assign acc_b_clip_en  = q.cc[`CSCR_CC_BCLIP_EN];
	assign store_clip_en  = q.cc[`CSCR_CC_SCLIP_EN];
	assign clip_width_sel = q.cc[`CSCR_CC_CLIP_W];
	assign round_style    = q.cc[`CSCR_CC_ROUND];
	assign int_mul_sel    = q.cc[`CSCR_CC_INT_MUL];
	// full 64K range while frame live
	assign ptr_full_range = stack_frame_live;

	////////////////////////////////////////////////////////////////////////
	// Checks
	property p_sticky_hold;
		@(posedge clk) disable iff (!rst_n)
		acc_a_sat_evt |=> q.st[`CSCR_ST_ACLIP];
	endproperty
	a_sticky_hold: assert property (p_sticky_hold)
		else $error("sticky A not set");

	// Only a status write may drop the sticky flag
	property p_sticky_keep;
		@(posedge clk) disable iff (!rst_n)
		(q.st[`CSCR_ST_ACLIP] && !(reg_wr && reg_sel == `CSCR_SEL_STATUS))
			|=> q.st[`CSCR_ST_ACLIP];
	endproperty
	a_sticky_keep: assert property (p_sticky_keep)
		else $error("sticky A lost without a write");

	property p_block;
		@(posedge clk) disable iff (!rst_n)
		(cpu_priority == 4'h7 || cpu_priority[3]) |-> user_irq_block;
	endproperty
	a_block: assert property (p_block)
		else $error("user interrupts not blocked");

	property p_unblock;
		@(posedge clk) disable iff (!rst_n)
		(cpu_priority != 4'h7 && !cpu_priority[3]) |-> !user_irq_block;
	endproperty
	a_unblock: assert property (p_unblock)
		else $error("user interrupts blocked below level 7");

	property p_ipl_lock;
		@(posedge clk) disable iff (!rst_n)
		(nesting_disable && !prio_load) |=>
			$stable(q.st[`CSCR_ST_LVL_HI:`CSCR_ST_LVL_LO]);
	endproperty
	a_ipl_lock: assert property (p_ipl_lock)
		else $error("priority changed while locked");

	property p_prio_load;
		@(posedge clk) disable iff (!rst_n)
		prio_load |=> cpu_priority == $past(prio_value);
	endproperty
	a_prio_load: assert property (p_prio_load)
		else $error("priority level not loaded");

	// Back-to-back exit writes may keep the pulse high legally
	property p_edt_pulse;
		@(posedge clk) disable iff (!rst_n)
		(reg_wr && reg_sel == `CSCR_SEL_CONTROL && reg_wdata[`CSCR_CC_EXIT])
			|=> do_loop_early_exit;
	endproperty
	a_edt_pulse: assert property (p_edt_pulse)
		else $error("early exit pulse missing");

	property p_edt_only;
		@(posedge clk) disable iff (!rst_n)
		!(reg_wr && reg_sel == `CSCR_SEL_CONTROL &&
			reg_wdata[`CSCR_CC_EXIT]) |=> !do_loop_early_exit;
	endproperty
	a_edt_only: assert property (p_edt_only)
		else $error("early exit pulse without a write");

	property p_zero_clear;
		@(posedge clk) disable iff (!rst_n)
		(alu_upd && alu_result != 16'h0000 && !alu_is_byte)
			|=> !q.st[`CSCR_ST_ZERO];
	endproperty
	a_zero_clear: assert property (p_zero_clear)
		else $error("zero flag not cleared");

	property p_carry;
		@(posedge clk) disable iff (!rst_n)
		alu_upd |=> q.st[`CSCR_ST_CARRY] == $past(alu_carry);
	endproperty
	a_carry: assert property (p_carry)
		else $error("carry flag wrong");

	property p_half_word;
		@(posedge clk) disable iff (!rst_n)
		(alu_upd && !alu_is_byte)
			|=> q.st[`CSCR_ST_HALF] == $past(alu_half_w);
	endproperty
	a_half_word: assert property (p_half_word)
		else $error("word half carry wrong");

	property p_rsvd_us;
		@(posedge clk) disable iff (!rst_n)
		dsp_mul_signedness != `CSCR_MUL_RSVD;
	endproperty
	a_rsvd_us: assert property (p_rsvd_us)
		else $error("reserved signedness held");

	property p_depth_rd;
		@(posedge clk) disable iff (!rst_n)
		(reg_sel == `CSCR_SEL_CONTROL) |=>
			reg_rdata[`CSCR_CC_NEST_HI:`CSCR_CC_NEST_LO] ==
				$past(do_nesting_depth);
	endproperty
	a_depth_rd: assert property (p_depth_rd)
		else $error("depth read mismatch");
endmodule // cscr_regs

/* File: test/cscr_regs_tb_top.sv */
`timescale 1ns/10ps
`include "cscr_regs.svh"
module cscr_regs_tb_top;
	logic                clk;
	logic                rst_n;
	logic [1:0]          reg_sel;
	logic                reg_wr;
	logic [15:0]         reg_wdata;
	logic [15:0]         reg_rdata;
	logic [3:0]          acc_ev;     // a ovf, b ovf, a sat, b sat
	logic                alu_upd;
	logic [15:0]         alu_result;
	logic [4:0]          alu_misc;   // carry, half_b, half_w, byte, ovf
	logic [1:0]          loop_busy;
	logic [2:0]          depth;
	logic                sfl;
	logic [5:0]          wset;
	logic                nst_dis;
	logic                prio_load;
	logic [3:0]          prio_value;
	logic [3:0]          cpu_priority;
	logic                irq_block;
	logic [7:0]          ctl_out;
	cscr_pkg::cscr_mul_t mul;
	logic                early_exit;
	int                  errors;
	int                  comparisons;

	////////////////////////////////////////////////////////////////////////
	// Clock of 4 ns
	always #2 clk = ~clk;

	cscr_regs dut (
		.clk(clk), .rst_n(rst_n), .reg_sel(reg_sel), .reg_wr(reg_wr),
		.reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
		.acc_a_overflow_in(acc_ev[3]), .acc_b_overflow_in(acc_ev[2]),
		.acc_a_sat_evt(acc_ev[1]), .acc_b_sat_evt(acc_ev[0]),
		.alu_upd(alu_upd), .alu_result(alu_result),
		.alu_carry(alu_misc[4]), .alu_half_b(alu_misc[3]),
		.alu_half_w(alu_misc[2]), .alu_is_byte(alu_misc[1]),
		.alu_ovf(alu_misc[0]), .do_loop_busy(loop_busy[1]),
		.repeat_loop_busy(loop_busy[0]), .do_nesting_depth(depth),
		.stack_frame_live(sfl), .active_wset_id(wset[5:3]),
		.manual_wset_id(wset[2:0]), .nesting_disable(nst_dis),
		.prio_load(prio_load), .prio_value(prio_value),
		.cpu_priority(cpu_priority), .user_irq_block(irq_block),
		.var_latency_en(ctl_out[7]), .dsp_mul_signedness(mul),
		.do_loop_early_exit(early_exit), .acc_a_clip_en(ctl_out[6]),
		.acc_b_clip_en(ctl_out[5]), .store_clip_en(ctl_out[4]),
		.clip_width_sel(ctl_out[3]), .round_style(ctl_out[2]),
		.int_mul_sel(ctl_out[1]), .ptr_full_range(ctl_out[0])
	);

	////////////////////////////////////////////////////////////////////////
	// Case equality so that unknowns never pass
	task automatic chk(input string what, input logic [15:0] exp,
		input logic [15:0] got);
		comparisons++;
		if (got !== exp) begin
			errors++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask

	// Strobe is dropped at the taking edge, never re-raised in that step
	task automatic wr(input logic [1:0] s, input logic [15:0] d);
		@(posedge clk);
		reg_sel <= s;
		reg_wr <= 1'b1;
		reg_wdata <= d;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask

	// Extra edge gives margin over the registered read path
	task automatic rd(input logic [1:0] s, input logic [15:0] exp,
		input string what);
		@(posedge clk);
		reg_sel <= s;
		@(posedge clk);
		@(posedge clk);
		#1 chk(what, exp, reg_rdata);
	endtask

	task automatic ev(input logic [3:0] m);
		@(posedge clk);
		acc_ev <= m;
		@(posedge clk);
		acc_ev <= 4'h0;
	endtask

	task automatic alu(input logic [15:0] r, input logic [4:0] m);
		@(posedge clk);
		alu_upd <= 1'b1;
		alu_result <= r;
		alu_misc <= m;
		@(posedge clk);
		alu_upd <= 1'b0;
	endtask

	task automatic prio(input logic [3:0] v);
		@(posedge clk);
		prio_load <= 1'b1;
		prio_value <= v;
		@(posedge clk);
		prio_load <= 1'b0;
		#1;
	endtask

	////////////////////////////////////////////////////////////////////////
	// Scenarios
	task automatic t_reset;
		rd(`CSCR_SEL_STATUS, 16'h0000, "status reset");
		rd(`CSCR_SEL_CONTROL, 16'h0020, "control reset");
		rd(2'h3, 16'h0000, "unmapped read");
	endtask

	// All ones: reserved code, read-only and set-proof bits are refused
	task automatic t_control;
		@(posedge clk);
		depth <= 3'h7;
		sfl <= 1'b1;
		wr(`CSCR_SEL_CONTROL, 16'hffff);
		#1 chk("exit pulse", 16'h0001, {15'h0, early_exit});
		@(posedge clk);
		#1 chk("exit end", 16'h0000, {15'h0, early_exit});
		chk("ctl outs", 16'h00ff, {8'h00, ctl_out});
		chk("mul keep", 16'h0000, {14'h0, mul});
		rd(`CSCR_SEL_CONTROL, 16'h87f7, "control view");
		for (int i = 0; i < 3; i++) begin
			wr(`CSCR_SEL_CONTROL, 16'h0020 | (16'(i) << 12));
			#1 chk("mul code", 16'(i), {14'h0, mul});
		end
		wr(`CSCR_SEL_CONTROL, 16'hffff);
		#1 chk("mul rsvd", 16'h0002, {14'h0, mul});
		wr(`CSCR_SEL_CONTROL, 16'h0020);
		#1 chk("ctl low", 16'h0011, {8'h00, ctl_out});
	endtask

	task automatic t_acc;
		ev(4'b1000);
		ev(4'b0001);
		rd(`CSCR_SEL_STATUS, 16'h9c00, "acc flags");
		wr(`CSCR_SEL_STATUS, 16'h2400);
		rd(`CSCR_SEL_STATUS, 16'h2400, "sticky write");
		wr(`CSCR_SEL_STATUS, 16'h2000);
		rd(`CSCR_SEL_STATUS, 16'h0000, "combined clr");
		ev(4'b0110);
		rd(`CSCR_SEL_STATUS, 16'h6c00, "acc flags b");
		// Clear write and B saturation land in one cycle: set wins
		@(posedge clk);
		acc_ev <= 4'b0001;
		reg_sel <= `CSCR_SEL_STATUS;
		reg_wr <= 1'b1;
		reg_wdata <= 16'h0000;
		@(posedge clk);
		acc_ev <= 4'h0;
		reg_wr <= 1'b0;
		rd(`CSCR_SEL_STATUS, 16'h1400, "set beats clr");
		wr(`CSCR_SEL_STATUS, 16'h0000);
		rd(`CSCR_SEL_STATUS, 16'h0000, "all clr");
	endtask

	task automatic t_prio;
		prio(4'h5);
		chk("prio 5", 16'h0005, {11'h0, irq_block, cpu_priority});
		rd(`CSCR_SEL_STATUS, 16'h00a0, "prio view");
		@(posedge clk);
		nst_dis <= 1'b1;
		wr(`CSCR_SEL_STATUS, 16'h0000);
		rd(`CSCR_SEL_STATUS, 16'h00a0, "prio locked");
		@(posedge clk);
		nst_dis <= 1'b0;
		wr(`CSCR_SEL_STATUS, 16'h00e0);
		#1 chk("prio 7", 16'h0017, {11'h0, irq_block, cpu_priority});
		prio(4'h8);
		chk("prio 8", 16'h0018, {11'h0, irq_block, cpu_priority});
		rd(`CSCR_SEL_CONTROL, 16'h072c, "top view");
		wr(`CSCR_SEL_CONTROL, 16'h0020);
		#1 chk("top clr", 16'h0000, {11'h0, irq_block, cpu_priority});
	endtask

	// Word then byte half carry; zero flag set and then cleared
	task automatic t_alu;
		wr(`CSCR_SEL_STATUS, 16'h0000);
		alu(16'h8000, 5'b10101);
		rd(`CSCR_SEL_STATUS, 16'h010d, "alu word");
		alu(16'h0000, 5'b01010);
		rd(`CSCR_SEL_STATUS, 16'h0102, "alu byte");
		alu(16'h0001, 5'b00000);
		rd(`CSCR_SEL_STATUS, 16'h0000, "alu nonzero");
	endtask

	task automatic t_views;
		@(posedge clk);
		loop_busy <= 2'b11;
		wset <= 6'o21;
		sfl <= 1'b0;
		rd(`CSCR_SEL_STATUS, 16'h0210, "loop busy");
		rd(`CSCR_SEL_WSET, 16'h0201, "wset view");
		chk("frame off", 16'h0000, {15'h0, ctl_out[0]});
	endtask

	////////////////////////////////////////////////////////////////////////
	// Single place where the run ends
	task automatic test_done;
		$display("errors %0d comparisons %0d", errors, comparisons);
		if (errors == 0 && comparisons > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	// Watchdog, far beyond the under 130 cycles the tests need
	initial begin
		repeat (5000) @(posedge clk);
		errors++;
		test_done;
	end

	initial begin
		clk = 1'b0;
		rst_n = 1'b0;
		{reg_sel, reg_wr, reg_wdata, acc_ev, alu_upd, alu_result} = '0;
		{alu_misc, loop_busy, depth, sfl, wset, nst_dis} = '0;
		{prio_load, prio_value} = '0;
		errors = 0;
		comparisons = 0;
		repeat (20) @(posedge clk);
		rst_n <= 1'b1;
		t_reset;
		t_control;
		t_acc;
		t_prio;
		t_alu;
		t_views;
		test_done;
	end
endmodule // cscr_regs_tb_top
